// file: counter_pkg.sv
// Shared constants for the multimode event and frequency counter
package counter_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
   localparam logic [7:0] CTRL_TWO_OFFSET = 8'h04;
   localparam logic [7:0] COMPARE_OFFSET = 8'h08;
   localparam logic [7:0] GATE_PERIOD_OFFSET = 8'h0c;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;
   // ctrl_reg_one fields
   localparam int MODE_POS = 0;
   localparam int SRC_CLK_POS = 2;
   localparam int RUN_POS = 5;
   localparam int CLEAR_POS = 7;
   // ctrl_reg_two fields
   localparam int EDGE_SEL_POS = 0;
   localparam int GATE_SRC_POS = 1;
   localparam int WIN_EDGE_POS = 3;
   localparam int GATE_CLK_POS = 4;
   localparam int AUX_ROUTE_POS = 6;
   // gate_period_reg fields and status bits
   localparam int HIGH_SET_POS = 0;
   localparam int LOW_SET_POS = 4;
   localparam int OVF_POS = 0;
   localparam int WIN_ACT_POS = 1;
   // Reset values
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   localparam logic [6:0] CTRL_TWO_RESET = 7'h00;
   localparam logic [7:0] GATE_PERIOD_RESET = 8'h00;
   localparam logic [17:0] COMPARE_RESET = 18'h00001;
   // Counter geometry
   localparam int COUNT_WIDTH = 18;
   localparam int COMPARE_HIGH_BITS = 7;
   localparam int GATE_STEPS = 16;
   localparam int FAST_DIV_WIDTH = 23;
   localparam int SLOW_DIV_WIDTH = 15;
   // Field encodings
   localparam logic [1:0] RUN_START = 2'h2;
   localparam logic [1:0] GATE_FROM_EXT = 2'h0;
   localparam logic [1:0] GATE_INTERNAL = 2'h1;
   localparam logic [1:0] GATE_FROM_AUX = 2'h2;
   localparam logic [2:0] SRC_FAST = 3'h5;
   localparam logic [2:0] SRC_SLOW = 3'h6;
   localparam logic [2:0] SRC_EXT = 3'h7;
   typedef enum logic [1:0] {
      MODE_TIMER_EVENT = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_PULSE_WIDTH = 2'h2,
      MODE_FREQUENCY = 2'h3
   } mode_type;
endpackage : counter_pkg

// file: multimode_event_freq_counter.sv
// Multimode event and frequency counter with AHB-Lite register slave
// Overview of operation
// - Timer mode counts internal clock, matches, clears
// - Fast source in slow mode compares top seven
// - Timer mode serves as oscillator warm-up timer
// - Event mode counts external input falling edges
// - Event mode match interrupts, clears, keeps counting
// - Pulse mode counts falling edges of gated AND
// - Pulse mode interrupt on falling or both edges
// - Uncleared counter resumes from stopped value
// - Wrap sets overflow until clear bit
// - Stopping pulse mode with input high interrupts
// - Starting pulse mode, both edges, input high interrupts
// - Window active flag meaningless in pulse mode
// - Input falling with clock high adds one
// - Frequency mode counts input edges while gate high
// - Frequency mode interrupt on gate falling or both
// - Window active flag shows gate state
// - Route bit set blocks companion output from pin
// - Gate high period is sixteen minus setting
// - Gate low period scales the same way
// - Window flag high only during counting high period
// - Low setting written in low period applies next
`timescale 1ns/1ns
`default_nettype none
module multimode_event_freq_counter #(
   parameter int CNT_WIDTH = counter_pkg::COUNT_WIDTH
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic EXT_COUNT_IN_I,
   input wire logic AUX_TIMER_OUT_I,
   input wire logic SLOW_OSC_TICK_I,
   input wire logic SLOW_MODE_I,
   input wire logic DIVIDER_TAP_SEL_I,
   output logic COUNTER_MATCH_IRQ_O,
   output logic SHARED_PORT_PIN_O,
   output logic SHARED_PORT_PIN_OEN_O
);
   import counter_pkg::*;

   if (CNT_WIDTH < 1 || CNT_WIDTH > COUNT_WIDTH) begin : g_width_check
      $error("Counter width must lie between 1 and the compare register width");
   end

   // A narrower counter wraps early; registers and bus stay full width.
   // The compare high bits keep their place in the full-width register.
   localparam logic [17:0] CNT_MASK = 18'((64'h1 << CNT_WIDTH) - 64'h1);

   // Bus and register group
   logic pend_reg, pend_next;
   logic pwrite_reg, pwrite_next;
   logic [7:0] paddr_reg, paddr_next;
   logic ready_reg, ready_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] ctrl_reg_one, ctrl_reg_one_next;
   logic [6:0] ctrl_reg_two, ctrl_reg_two_next;
   logic [17:0] compare_count_reg, compare_count_reg_next;
   logic [7:0] gate_period_reg, gate_period_reg_next;
   logic counter_clear_bit;

   // Counter group
   logic [17:0] cnt_reg, cnt_next;
   logic overflow_flag_reg, overflow_flag_next;
   logic irq_reg, irq_next;
   logic cnt_lvl_reg, cnt_lvl_next;
   logic win_lvl_reg, win_lvl_next;
   logic window_active_flag_reg, window_active_flag_next;
   logic [FAST_DIV_WIDTH-1:0] fdiv_reg, fdiv_next;
   logic [SLOW_DIV_WIDTH-1:0] sdiv_reg, sdiv_next;
   logic gate_high_reg, gate_high_next;
   logic [4:0] gate_cnt_reg, gate_cnt_next;
   logic [3:0] low_latch_reg, low_latch_next;
   logic pin_reg, pin_next;
   logic pin_oen_reg, pin_oen_next;

   mode_type mode;
   logic [2:0] src_clk_sel;
   logic [1:0] run_ctrl;
   logic [1:0] gate_source_sel;
   logic [1:0] gate_clk_sel;
   logic win_irq_edge_sel;
   logic aux_pin_route;
   logic running;

   assign mode = mode_type'(ctrl_reg_one[MODE_POS +: 2]);
   assign src_clk_sel = ctrl_reg_one[SRC_CLK_POS +: 3];
   assign run_ctrl = ctrl_reg_one[RUN_POS +: 2];
   assign gate_source_sel = ctrl_reg_two[GATE_SRC_POS +: 2];
   assign win_irq_edge_sel = ctrl_reg_two[WIN_EDGE_POS];
   assign gate_clk_sel = ctrl_reg_two[GATE_CLK_POS +: 2];
   assign aux_pin_route = ctrl_reg_two[AUX_ROUTE_POS];
   assign running = (run_ctrl == RUN_START);

   // One wait state per transfer so read data leave straight from a flop
   always_comb begin
      pend_next = 1'b0;
      pwrite_next = pwrite_reg;
      paddr_next = paddr_reg;
      ready_next = 1'b1;
      rdata_next = rdata_reg;
      ctrl_reg_one_next = ctrl_reg_one;
      ctrl_reg_two_next = ctrl_reg_two;
      compare_count_reg_next = compare_count_reg;
      gate_period_reg_next = gate_period_reg;
      counter_clear_bit = 1'b0;
      if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
         pend_next = 1'b1;
         pwrite_next = HWRITE_I;
         paddr_next = HADDR_I[7:0];
         ready_next = 1'b0;
      end
      if (pend_reg) begin
         rdata_next = 32'h0;
         if (pwrite_reg) begin
            unique case (paddr_reg)
               CTRL_ONE_OFFSET: begin
                  ctrl_reg_one_next = {1'b0, HWDATA_I[6:0]};
                  counter_clear_bit = HWDATA_I[CLEAR_POS];
               end
               CTRL_TWO_OFFSET: ctrl_reg_two_next = HWDATA_I[6:0];
               COMPARE_OFFSET: compare_count_reg_next = HWDATA_I[17:0];
               GATE_PERIOD_OFFSET: gate_period_reg_next = HWDATA_I[7:0];
               default: ;
            endcase
         end else begin
            unique case (paddr_reg)
               CTRL_ONE_OFFSET: rdata_next = {24'h0, ctrl_reg_one};
               CTRL_TWO_OFFSET: rdata_next = {25'h0, ctrl_reg_two};
               // The compare address reads back the live count, not the compare value
               COMPARE_OFFSET: rdata_next = {14'h0, cnt_reg};
               GATE_PERIOD_OFFSET: rdata_next = {24'h0, gate_period_reg};
               STATUS_OFFSET: rdata_next = {30'h0, window_active_flag_reg, overflow_flag_reg};
               default: rdata_next = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         pend_reg <= 1'b0;
         pwrite_reg <= 1'b0;
         paddr_reg <= 8'h00;
         ready_reg <= 1'b1;
         rdata_reg <= 32'h0;
         ctrl_reg_one <= CTRL_ONE_RESET;
         ctrl_reg_two <= CTRL_TWO_RESET;
         compare_count_reg <= COMPARE_RESET;
         gate_period_reg <= GATE_PERIOD_RESET;
      end else begin
         pend_reg <= pend_next;
         pwrite_reg <= pwrite_next;
         paddr_reg <= paddr_next;
         ready_reg <= ready_next;
         rdata_reg <= rdata_next;
         ctrl_reg_one <= ctrl_reg_one_next;
         ctrl_reg_two <= ctrl_reg_two_next;
         compare_count_reg <= compare_count_reg_next;
         gate_period_reg <= gate_period_reg_next;
      end
   end

   // Counter, gate generator and dividers
   logic slow_taps;
   logic src_lvl;
   logic gate_lvl;
   logic gate_tick;
   logic count_evt;
   logic [4:0] gate_idx;
   logic [13:0] fmask;
   logic [5:0] smask;
   logic [17:0] inc;
   logic [4:0] gate_limit;
   logic compare_hit;
   logic internal_gate_on;

   always_comb begin
      fdiv_next = fdiv_reg + 1'b1;
      sdiv_next = sdiv_reg + {{(SLOW_DIV_WIDTH-1){1'b0}}, SLOW_OSC_TICK_I};
      slow_taps = SLOW_MODE_I | DIVIDER_TAP_SEL_I;
      // Source clock as a square level; its falling edge is the count tick.
      // The full-rate fast source can only be shown as half rate here.
      unique case (src_clk_sel)
         3'h0: src_lvl = slow_taps ? sdiv_reg[14] : fdiv_reg[22];
         3'h1: src_lvl = slow_taps ? sdiv_reg[4] : fdiv_reg[12];
         3'h2: src_lvl = slow_taps ? sdiv_reg[2] : fdiv_reg[10];
         3'h3: src_lvl = fdiv_reg[6];
         3'h4: src_lvl = fdiv_reg[2];
         SRC_FAST: src_lvl = fdiv_reg[0];
         SRC_SLOW: src_lvl = sdiv_reg[0];
         SRC_EXT: src_lvl = EXT_COUNT_IN_I;
      endcase
      // Gate step: fast 2^12..2^14 or slow 2^4..2^6 periods
      gate_idx = {3'h0, gate_clk_sel};
      fmask = 14'h0fff;
      smask = 6'h0f;
      if (gate_clk_sel == 2'h1) begin
         fmask = 14'h1fff;
         smask = 6'h1f;
      end else if (gate_clk_sel == 2'h2) begin
         fmask = 14'h3fff;
         smask = 6'h3f;
      end
      if (slow_taps) begin
         gate_tick = SLOW_OSC_TICK_I && ((sdiv_reg[5:0] & smask) == smask);
      end else begin
         gate_tick = (fdiv_reg[13:0] & fmask) == fmask;
      end
      gate_high_next = gate_high_reg;
      gate_cnt_next = gate_cnt_reg;
      low_latch_next = low_latch_reg;
      gate_limit = gate_high_reg ? 5'(GATE_STEPS) - {1'b0, gate_period_reg[HIGH_SET_POS +: 4]}
                                 : 5'(GATE_STEPS) - {1'b0, low_latch_reg};
      internal_gate_on = running && (mode == MODE_FREQUENCY) && (gate_source_sel == GATE_INTERNAL);
      if (!internal_gate_on) begin
         gate_high_next = 1'b1;
         gate_cnt_next = 5'h00;
      end else if (gate_tick) begin
         if (gate_cnt_reg + 5'h01 >= gate_limit) begin
            gate_cnt_next = 5'h00;
            gate_high_next = !gate_high_reg;
            if (gate_high_reg) begin
               // Low setting is sampled only on entering a low period
               low_latch_next = gate_period_reg[LOW_SET_POS +: 4];
            end
         end else begin
            gate_cnt_next = gate_cnt_reg + 5'h01;
         end
      end
      unique case (gate_source_sel)
         GATE_FROM_EXT: gate_lvl = EXT_COUNT_IN_I;
         GATE_INTERNAL: gate_lvl = gate_high_reg;
         GATE_FROM_AUX: gate_lvl = AUX_TIMER_OUT_I;
         default: gate_lvl = 1'b0;
      endcase
      // Counting level per mode; the count event is its falling edge
      cnt_lvl_next = 1'b0;
      win_lvl_next = 1'b0;
      unique case (mode)
         MODE_TIMER_EVENT: cnt_lvl_next = running && src_lvl;
         MODE_PULSE_WIDTH: begin
            cnt_lvl_next = running && EXT_COUNT_IN_I && src_lvl;
            win_lvl_next = running && EXT_COUNT_IN_I;
         end
         MODE_FREQUENCY: begin
            cnt_lvl_next = running && EXT_COUNT_IN_I && gate_lvl;
            win_lvl_next = running && gate_lvl;
         end
         MODE_RESERVED: ;
      endcase
      // A stop in timer or event mode must not leave a stray tick
      count_evt = cnt_lvl_reg && !cnt_lvl_next && (running || mode != MODE_TIMER_EVENT);
      inc = (cnt_reg + 18'h00001) & CNT_MASK;
      if (src_clk_sel == SRC_FAST && SLOW_MODE_I) begin
         compare_hit = inc[17 -: COMPARE_HIGH_BITS] ==
                       compare_count_reg[17 -: COMPARE_HIGH_BITS];
      end else begin
         compare_hit = inc == compare_count_reg;
      end
      cnt_next = cnt_reg;
      irq_next = 1'b0;
      if (count_evt) begin
         if (mode == MODE_TIMER_EVENT && compare_hit) begin
            cnt_next = 18'h00000;
            irq_next = 1'b1;
         end else begin
            cnt_next = inc;
         end
      end
      if (counter_clear_bit) begin
         cnt_next = 18'h00000;
      end
      if ((win_lvl_reg && !win_lvl_next) || (win_irq_edge_sel && !win_lvl_reg && win_lvl_next)) begin
         irq_next = 1'b1;
      end
      // Wrap sets the flag; a set in the clearing cycle still wins
      overflow_flag_next = (overflow_flag_reg && !counter_clear_bit) ||
                           (count_evt && (cnt_reg == CNT_MASK) && !(mode == MODE_TIMER_EVENT && compare_hit));
      window_active_flag_next = (mode == MODE_FREQUENCY) && running && gate_lvl;
      pin_next = AUX_TIMER_OUT_I && !aux_pin_route;
      pin_oen_next = aux_pin_route;
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         cnt_reg <= 18'h00000;
         overflow_flag_reg <= 1'b0;
         irq_reg <= 1'b0;
         cnt_lvl_reg <= 1'b0;
         win_lvl_reg <= 1'b0;
         window_active_flag_reg <= 1'b0;
         fdiv_reg <= '0;
         sdiv_reg <= '0;
         gate_high_reg <= 1'b1;
         gate_cnt_reg <= 5'h00;
         low_latch_reg <= 4'h0;
         pin_reg <= 1'b0;
         pin_oen_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         overflow_flag_reg <= overflow_flag_next;
         irq_reg <= irq_next;
         cnt_lvl_reg <= cnt_lvl_next;
         win_lvl_reg <= win_lvl_next;
         window_active_flag_reg <= window_active_flag_next;
         fdiv_reg <= fdiv_next;
         sdiv_reg <= sdiv_next;
         gate_high_reg <= gate_high_next;
         gate_cnt_reg <= gate_cnt_next;
         low_latch_reg <= low_latch_next;
         pin_reg <= pin_next;
         pin_oen_reg <= pin_oen_next;
      end
   end

   assign HRDATA_O = rdata_reg;
   assign HREADYOUT_O = ready_reg;
   assign HRESP_O = 1'b0;
   assign COUNTER_MATCH_IRQ_O = irq_reg;
   assign SHARED_PORT_PIN_O = pin_reg;
   assign SHARED_PORT_PIN_OEN_O = pin_oen_reg;
   // Bits kept for clarity or ignored by the word-only slave
   logic unused_gate_idx;
   assign unused_gate_idx = ^{gate_idx, HSIZE_I, HADDR_I[31:8], HWDATA_I[31:18]};
endmodule : multimode_event_freq_counter
`default_nettype wire

// file: multimode_event_freq_counter_chk.sv
// Port-level assertion checker for the multimode counter
`timescale 1ns/1ns
`default_nettype none
module multimode_event_freq_counter_chk
   import counter_pkg::*;
#(
   parameter int CNT_WIDTH = COUNT_WIDTH
) (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic AUX_TIMER_OUT_I,
   input wire logic COUNTER_MATCH_IRQ_O,
   input wire logic SHARED_PORT_PIN_O,
   input wire logic SHARED_PORT_PIN_OEN_O
);
   logic take;
   logic wr_q;
   logic rd_q;
   logic [7:0] a_q;
   logic [7:0] one_q;
   logic route_q;
   logic stop_tm;
   logic stopped;
   assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign stopped = one_q[6:5] != RUN_START;
   assign stop_tm = stopped && one_q[1:0] == MODE_TIMER_EVENT;
   // Shadow of the control bits, updated at the same edge as the slave's registers
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q <= 8'h00;
         one_q <= 8'h00;
         route_q <= 1'b0;
      end else begin
         wr_q <= take && HWRITE_I;
         rd_q <= take && !HWRITE_I;
         if (take) a_q <= HADDR_I[7:0];
         if (wr_q && a_q == CTRL_ONE_OFFSET) one_q <= HWDATA_I[7:0];
         if (wr_q && a_q == CTRL_TWO_OFFSET) route_q <= HWDATA_I[AUX_ROUTE_POS];
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   property p_pin_follow;
      $past(RESETN_I) && !SHARED_PORT_PIN_OEN_O |-> SHARED_PORT_PIN_O == $past(AUX_TIMER_OUT_I);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin does not follow companion output");
   property p_pin_block;
      SHARED_PORT_PIN_OEN_O |-> !SHARED_PORT_PIN_O;
   endproperty
   a_pin_block: assert property (p_pin_block) else $error("blocked pin still driven high");
   property p_route;
      RESETN_I |=> SHARED_PORT_PIN_OEN_O == $past(route_q);
   endproperty
   a_route: assert property (p_route) else $error("pin enable disagrees with route bit");
   property p_irq_pulse;
      COUNTER_MATCH_IRQ_O |=> !COUNTER_MATCH_IRQ_O;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse longer than one cycle");
   property p_quiet;
      stop_tm && $past(stop_tm) && $past(stop_tm, 2) && $past(stop_tm, 3) |-> !COUNTER_MATCH_IRQ_O;
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt while timer stopped");
   property p_cmp_width;
      rd_q && a_q == COMPARE_OFFSET |=> HRDATA_O[31:CNT_WIDTH] == '0;
   endproperty
   a_cmp_width: assert property (p_cmp_width) else $error("count wider than counter");
   property p_win_stop;
      rd_q && a_q == STATUS_OFFSET && stopped && $past(stopped) && $past(stopped, 2) |=> !HRDATA_O[WIN_ACT_POS];
   endproperty
   a_win_stop: assert property (p_win_stop) else $error("window flag set while stopped");
   property p_bus_wait;
      take |=> !HREADYOUT_O ##1 HREADYOUT_O;
   endproperty
   a_bus_wait: assert property (p_bus_wait) else $error("wait state count wrong");
endmodule : multimode_event_freq_counter_chk
bind multimode_event_freq_counter multimode_event_freq_counter_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
   .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
   .HREADYOUT_O(HREADYOUT_O), .AUX_TIMER_OUT_I(AUX_TIMER_OUT_I), .COUNTER_MATCH_IRQ_O(COUNTER_MATCH_IRQ_O),
   .SHARED_PORT_PIN_O(SHARED_PORT_PIN_O), .SHARED_PORT_PIN_OEN_O(SHARED_PORT_PIN_OEN_O)
);
`default_nettype wire

// file: pulse_source_model.sv
// Behavioural external pulse source, companion timer output and slow tick
`timescale 1ns/1ns
`default_nettype none
module pulse_source_model #(
   parameter int AUX_HALF = 40
) (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic level_i,
   input wire logic [7:0] half_i,
   output logic ext_o,
   output logic aux_o,
   output logic tick_o
);
   logic [7:0] ext_cnt = 8'h00;
   logic [7:0] half;
   int aux_cnt = 0;
   logic [2:0] tick_cnt = 3'h0;
   initial ext_o = 1'b0;
   initial aux_o = 1'b0;
   initial tick_o = 1'b0;
   // Rate capped at a sixteenth of the clock, each level eight cycles at least
   assign half = (half_i < 8'h08) ? 8'h08 : half_i;
   always @(posedge clk_i) begin
      tick_cnt <= tick_cnt + 3'h1;
      tick_o <= tick_cnt == 3'h0;
      // Companion timer runs free; the route bit never stops it
      aux_cnt <= (aux_cnt == AUX_HALF - 1) ? 0 : aux_cnt + 1;
      if (aux_cnt == AUX_HALF - 1) aux_o <= !aux_o;
      if (!run_i) begin
         ext_o <= level_i;
         ext_cnt <= 8'h00;
      end else if (ext_cnt == half - 8'h01) begin
         ext_o <= !ext_o;
         ext_cnt <= 8'h00;
      end else begin
         ext_cnt <= ext_cnt + 8'h01;
      end
   end
endmodule : pulse_source_model
`default_nettype wire

// file: test_multimode_event_freq_counter.sv
// Self-checking testbench for the multimode counter
`timescale 1ns/1ns
`default_nettype none
module test_multimode_event_freq_counter;
   import counter_pkg::*;
   // Narrow counter so a wrap fits in a short run
   localparam int CW = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic slow = 1'b0;
   logic tap = 1'b0;
   logic src_run = 1'b0;
   logic src_lvl = 1'b0;
   logic [7:0] src_half = 8'h08;
   logic [31:0] hrdata;
   logic hready, hresp, irq, pin, oen, ext, aux, tick;
   int n_fail = 0;
   int check_count = 0;
   int irq_count = 0;
   multimode_event_freq_counter #(.CNT_WIDTH(CW)) dut (
      .CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .EXT_COUNT_IN_I(ext), .AUX_TIMER_OUT_I(aux),
      .SLOW_OSC_TICK_I(tick), .SLOW_MODE_I(slow), .DIVIDER_TAP_SEL_I(tap), .COUNTER_MATCH_IRQ_O(irq),
      .SHARED_PORT_PIN_O(pin), .SHARED_PORT_PIN_OEN_O(oen)
   );
   pulse_source_model u_src (
      .clk_i(clk), .run_i(src_run), .level_i(src_lvl), .half_i(src_half), .ext_o(ext), .aux_o(aux), .tick_o(tick)
   );
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) irq_count++;
   end
   task test_done;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 8);
      check({31'h0, hready}, 32'h1);
   endtask : rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask : bus
   // Cycles from one interrupt pulse to the next
   task gap(output int g);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 300);
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (irq !== 1'b1 && g < 300);
   endtask : gap
   task wait_aux(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (aux !== v && n < 100);
      repeat (4) @(posedge clk);
   endtask : wait_aux
   task regs_test;
      logic [31:0] q;
      bus(1'b0, CTRL_ONE_OFFSET, 32'h0, q); check(q, 32'(CTRL_ONE_RESET));
      bus(1'b0, CTRL_TWO_OFFSET, 32'h0, q); check(q, 32'(CTRL_TWO_RESET));
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(q, 32'h0);
      bus(1'b1, 8'h14, 32'hffffffff, q);
      bus(1'b0, 8'h14, 32'h0, q); check(q, 32'h0);
      bus(1'b1, GATE_PERIOD_OFFSET, 32'hffffffff, q);
      bus(1'b0, GATE_PERIOD_OFFSET, 32'h0, q); check(q, 32'h000000ff);
      bus(1'b1, CTRL_TWO_OFFSET, 32'h40, q);
      repeat (3) @(posedge clk);
      check({30'h0, oen, pin}, 32'h2);
      bus(1'b1, CTRL_TWO_OFFSET, 32'h0, q);
      repeat (3) @(posedge clk);
      check({31'h0, oen}, 32'h0);
   endtask : regs_test
   task timer_test;
      logic [31:0] q;
      int g;
      bus(1'b1, COMPARE_OFFSET, 32'h3, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h14, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h54, q);
      // Fast source steps every second cycle, three steps to a match
      gap(g); check(32'(g), 32'd6);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h14, q);
      bus(1'b0, COMPARE_OFFSET, 32'h0, q); check(32'(q < 32'h3), 32'h1);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h94, q);
      bus(1'b0, COMPARE_OFFSET, 32'h0, q); check(q, 32'h0);
      // Slow operation with the fast source: low compare bits ignored, every step matches
      slow <= 1'b1;
      bus(1'b1, COMPARE_OFFSET, 32'h5, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h54, q);
      gap(g); check(32'(g), 32'd2);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h14, q);
      slow <= 1'b0;
   endtask : timer_test
   task event_test;
      logic [31:0] q;
      int g;
      bus(1'b1, COMPARE_OFFSET, 32'h4, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h1c, q);
      src_run <= 1'b1;
      bus(1'b1, CTRL_ONE_OFFSET, 32'h5c, q);
      gap(g); check(32'(g), 32'd64);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h1c, q);
      src_run <= 1'b0;
      bus(1'b0, COMPARE_OFFSET, 32'h0, q); check(32'(q < 32'h4), 32'h1);
   endtask : event_test
   task pulse_test;
      logic [31:0] q;
      logic [31:0] d;
      int n;
      src_lvl <= 1'b1;
      bus(1'b1, CTRL_TWO_OFFSET, 32'h08, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h96, q);
      n = irq_count;
      bus(1'b1, CTRL_ONE_OFFSET, 32'h56, q);
      repeat (4) @(posedge clk);
      check(32'(irq_count - n), 32'h1);
      repeat (4500) @(posedge clk);
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(32'(q[OVF_POS]), 32'h1);
      n = irq_count;
      bus(1'b1, CTRL_ONE_OFFSET, 32'h16, q);
      repeat (4) @(posedge clk);
      check(32'(irq_count - n), 32'h1);
      bus(1'b0, COMPARE_OFFSET, 32'h0, d);
      repeat (8) @(posedge clk);
      bus(1'b0, COMPARE_OFFSET, 32'h0, q); check(q, d);
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(32'(q[OVF_POS]), 32'h1);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h96, q);
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(q, 32'h0);
      src_lvl <= 1'b0;
   endtask : pulse_test
   task freq_test;
      logic [31:0] q;
      logic [31:0] d;
      int g;
      bus(1'b1, CTRL_TWO_OFFSET, 32'h04, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h9f, q);
      src_run <= 1'b1;
      bus(1'b1, CTRL_ONE_OFFSET, 32'h5f, q);
      gap(g); check(32'(g), 32'd80);
      wait_aux(1'b1);
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(32'(q[WIN_ACT_POS]), 32'h1);
      wait_aux(1'b0);
      bus(1'b0, STATUS_OFFSET, 32'h0, q); check(32'(q[WIN_ACT_POS]), 32'h0);
      bus(1'b0, COMPARE_OFFSET, 32'h0, d); check(32'(d != 32'h0), 32'h1);
      repeat (8) @(posedge clk);
      bus(1'b0, COMPARE_OFFSET, 32'h0, q); check(q, d);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h1f, q);
      // External input as its own gate: one window per input period
      bus(1'b1, CTRL_TWO_OFFSET, 32'h00, q);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h5f, q);
      gap(g); check(32'(g), 32'd16);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h1f, q);
      // Internal gate on slow taps: one step of 16 slow ticks, 8 cycles each
      bus(1'b1, CTRL_TWO_OFFSET, 32'h02, q);
      bus(1'b1, GATE_PERIOD_OFFSET, 32'hff, q);
      tap <= 1'b1;
      bus(1'b1, CTRL_ONE_OFFSET, 32'h5f, q);
      gap(g); check(32'(g), 32'd256);
      bus(1'b1, CTRL_ONE_OFFSET, 32'h1f, q);
      tap <= 1'b0;
      src_run <= 1'b0;
   endtask : freq_test
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      regs_test();
      timer_test();
      event_test();
      pulse_test();
      freq_test();
      test_done();
   end
endmodule : test_multimode_event_freq_counter
`default_nettype wire
